// File: hw/bus_mode_consts.svh
// Constants for the external bus mode controller.
`ifndef BUS_MODE_CONSTS_SVH
`define BUS_MODE_CONSTS_SVH
`define BM_NUM_CS        4
`define BM_ADDR_W        24
`define BM_DATA_W        8
`define BM_LEN_W         4
`define BM_MODE_W        2
`define BM_MODE_NATIVE   2'h0
`define BM_MODE_CLASSIC  2'h1
`define BM_MODE_LATCH    2'h2
`define BM_CLASSIC_MIN   4'h1
`define BM_LATCH_MIN     4'h2
`define BM_LEN_ONE       4'h1
`define BM_IO_HI_MSB     15
`define BM_IO_HI_LSB     8
`define BM_MEM_HI_MSB    23
`define BM_MEM_HI_LSB    16
`define BM_PERIPH_TOP    8'h00
`endif

// File: hw/bus_mode_pkg.sv
// Types shared by the external bus mode controller.
package bus_mode_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T1   = 3'b001,
    ST_T2   = 3'b010,
    ST_WAIT = 3'b011,
    ST_T3   = 3'b100,
    ST_T4   = 3'b101
  } bus_state_t;
endpackage : bus_mode_pkg

// File: hw/cs_decoder.sv
// Chip-select decoder with fixed priority, lower number wins.
`timescale 1ns/1ps
`include "bus_mode_consts.svh"
module cs_decoder #(
  parameter int NUM_CS = `BM_NUM_CS
) (
  // Address and cycle type
  input  wire logic [`BM_ADDR_W-1:0] addr_i,
  input  wire logic                  mem_i,
  input  wire logic                  io_i,
  // Per chip-select configuration
  input  wire logic [NUM_CS-1:0]     cs_en_i,
  input  wire logic [NUM_CS-1:0]     cs_io_i,
  input  wire logic [NUM_CS*8-1:0]   cs_lbr_i,
  input  wire logic [NUM_CS*8-1:0]   cs_ubr_i,
  // One-hot selection
  output logic      [NUM_CS-1:0]     sel_o
);
  logic [NUM_CS-1:0] hit;
  logic [7:0]        mem_hi;
  logic [7:0]        io_hi;

  assign mem_hi = addr_i[`BM_MEM_HI_MSB:`BM_MEM_HI_LSB];
  assign io_hi  = addr_i[`BM_IO_HI_MSB:`BM_IO_HI_LSB];

  genvar g;
  generate
    for (g = 0; g < NUM_CS; g++) begin : g_hit
      assign hit[g] = cs_en_i[g] & (
        (!cs_io_i[g] && mem_i && mem_hi >= cs_lbr_i[g*8 +: 8]
                     && mem_hi <= cs_ubr_i[g*8 +: 8]) ||
        (cs_io_i[g] && io_i && io_hi == cs_lbr_i[g*8 +: 8]
                    && io_hi != `BM_PERIPH_TOP));
    end
  endgenerate

  // Isolate the lowest set bit for priority.
  assign sel_o = hit & (~hit + {{(NUM_CS-1){1'b0}}, 1'b1});
endmodule : cs_decoder

// File: hw/bus_mode_ctrl.sv
// External bus cycle shaper with per chip-select bus modes.
`timescale 1ns/1ps
`include "bus_mode_consts.svh"
module bus_mode_ctrl
  import bus_mode_pkg::*;
#(
  parameter int NUM_CS = `BM_NUM_CS
) (
  // Clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          rst_i,
  // Per chip-select configuration
  input  wire logic [NUM_CS-1:0]             cs_en_i,
  input  wire logic [NUM_CS-1:0]             cs_io_i,
  input  wire logic [NUM_CS*8-1:0]           cs_lbr_i,
  input  wire logic [NUM_CS*8-1:0]           cs_ubr_i,
  input  wire logic [NUM_CS*`BM_MODE_W-1:0]  cs_mode_i,
  input  wire logic [NUM_CS*`BM_LEN_W-1:0]   cs_len_i,
  input  wire logic [NUM_CS-1:0]             cs_mux_i,
  // Processor side
  input  wire logic                          cpu_req_i,
  input  wire logic                          cpu_write_i,
  input  wire logic                          cpu_mem_i,
  input  wire logic                          cpu_io_i,
  input  wire logic [`BM_ADDR_W-1:0]         cpu_addr_i,
  input  wire logic [`BM_DATA_W-1:0]         cpu_wdata_i,
  input  wire logic                          cpu_rd_n_i,
  input  wire logic                          cpu_wr_n_i,
  output logic                               cpu_ready_o,
  output logic [`BM_DATA_W-1:0]              cpu_rdata_o,
  // Bus arbitration pins
  input  wire logic                          bus_request_in_n_i,
  output logic                               bus_grant_out_n_o,
  // External master activity seen on the pins
  input  wire logic                          ext_mem_n_i,
  input  wire logic                          ext_io_n_i,
  output logic                               ext_internal_hit_o,
  // Bus pins
  input  wire logic                          wait_n_i,
  output logic [`BM_ADDR_W-1:0]              addr_o,
  input  wire logic [`BM_ADDR_W-1:0]         addr_i,
  output logic                               addr_oe_o,
  output logic [`BM_DATA_W-1:0]              data_o,
  input  wire logic [`BM_DATA_W-1:0]         data_i,
  output logic                               data_oe_o,
  output logic [NUM_CS-1:0]                  cs_n_o,
  output logic                               read_strobe_n_o,
  output logic                               write_strobe_n_o,
  output logic                               memory_request_n_o,
  output logic                               io_request_n_o,
  output logic                               address_latch_strobe_o,
  output logic                               inserted_wait_state_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] wait_s_q, breq_s_q, emem_s_q, eio_s_q;
  logic       wait_low, breq, ext_mem, ext_io;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wait_s_q <= 2'h3;
      breq_s_q <= 2'h3;
      emem_s_q <= 2'h3;
      eio_s_q  <= 2'h3;
    end else begin
      wait_s_q <= {wait_s_q[0], wait_n_i};
      breq_s_q <= {breq_s_q[0], bus_request_in_n_i};
      emem_s_q <= {emem_s_q[0], ext_mem_n_i};
      eio_s_q  <= {eio_s_q[0], ext_io_n_i};
    end
  end

  assign wait_low = !wait_s_q[1];
  assign breq     = !breq_s_q[1];
  assign ext_mem  = !emem_s_q[1];
  assign ext_io   = !eio_s_q[1];

  // ----------------------------------------------------------------
  // Chip-select decode
  // ----------------------------------------------------------------
  logic                  granted_q;
  logic [`BM_ADDR_W-1:0] dec_addr;
  logic                  dec_mem, dec_io;
  logic [NUM_CS-1:0]     sel;

  assign dec_addr = granted_q ? addr_i : cpu_addr_i;
  assign dec_mem  = granted_q ? ext_mem : cpu_mem_i;
  assign dec_io   = granted_q ? ext_io : cpu_io_i;

  cs_decoder #(.NUM_CS(NUM_CS)) u_dec (
    .addr_i   (dec_addr),
    .mem_i    (dec_mem),
    .io_i     (dec_io),
    .cs_en_i  (cs_en_i),
    .cs_io_i  (cs_io_i),
    .cs_lbr_i (cs_lbr_i),
    .cs_ubr_i (cs_ubr_i),
    .sel_o    (sel)
  );

  assign ext_internal_hit_o = granted_q && ext_io &&
      addr_i[`BM_IO_HI_MSB:`BM_IO_HI_LSB] == `BM_PERIPH_TOP;

  // ----------------------------------------------------------------
  // Per chip-select mode and length selection
  // ----------------------------------------------------------------
  logic [`BM_MODE_W-1:0] sel_mode;
  logic [`BM_LEN_W-1:0]  sel_len;
  logic                  sel_mux;

  always_comb begin
    sel_mode = `BM_MODE_NATIVE;
    sel_len  = `BM_LEN_ONE;
    sel_mux  = 1'b0;
    for (int i = 0; i < NUM_CS; i++) begin
      if (sel[i]) begin
        sel_mode = cs_mode_i[i*`BM_MODE_W +: `BM_MODE_W];
        sel_len  = cs_len_i[i*`BM_LEN_W +: `BM_LEN_W];
        sel_mux  = cs_mux_i[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Cycle state machine
  // ----------------------------------------------------------------
  bus_state_t            state_q;
  logic [`BM_LEN_W-1:0]  cnt_q, len_q;
  logic [`BM_MODE_W-1:0] mode_q;
  logic                  mux_q, write_q, mem_q;
  logic [NUM_CS-1:0]     sel_q;
  logic [`BM_ADDR_W-1:0] addr_q;
  logic [`BM_DATA_W-1:0] wdata_q;
  logic                  last_clk, shaped, start, done_q;

  assign shaped   = sel != '0 && sel_mode != `BM_MODE_NATIVE;
  // The edge that takes ready also ends the request, so no new cycle starts on it.
  assign start    = state_q == ST_IDLE && cpu_req_i && !granted_q && shaped && !done_q;
  assign last_clk = cnt_q == len_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      len_q   <= `BM_LEN_ONE;
      mode_q  <= `BM_MODE_NATIVE;
      mux_q   <= 1'b0;
      write_q <= 1'b0;
      mem_q   <= 1'b0;
      sel_q   <= '0;
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (start) begin
      mode_q  <= sel_mode;
      mux_q   <= sel_mux && sel_mode == `BM_MODE_LATCH;
      write_q <= cpu_write_i;
      mem_q   <= cpu_mem_i;
      sel_q   <= sel;
      addr_q  <= cpu_addr_i;
      wdata_q <= cpu_wdata_i;
      if (sel_mode == `BM_MODE_CLASSIC && sel_len < `BM_CLASSIC_MIN) begin
        len_q <= `BM_CLASSIC_MIN;
      end else if (sel_mode == `BM_MODE_LATCH && sel_len < `BM_LATCH_MIN) begin
        len_q <= `BM_LATCH_MIN;
      end else begin
        len_q <= sel_len;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= `BM_LEN_ONE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= `BM_LEN_ONE;
          if (start) begin
            state_q <= ST_T1;
          end
        end
        ST_T1: begin
          cnt_q <= last_clk ? `BM_LEN_ONE : cnt_q + `BM_LEN_ONE;
          if (last_clk) begin
            state_q <= ST_T2;
          end
        end
        ST_T2: begin
          cnt_q <= last_clk ? `BM_LEN_ONE : cnt_q + `BM_LEN_ONE;
          if (last_clk) begin
            state_q <= wait_low ? ST_WAIT : ST_T3;
          end
        end
        ST_WAIT: begin
          cnt_q <= `BM_LEN_ONE;
          if (!wait_low) begin
            state_q <= ST_T3;
          end
        end
        // T3 then T4 in latch mode
        ST_T3: begin
          cnt_q <= last_clk ? `BM_LEN_ONE : cnt_q + `BM_LEN_ONE;
          if (last_clk) begin
            state_q <= mode_q == `BM_MODE_LATCH ? ST_T4 : ST_IDLE;
          end
        end
        ST_T4: begin
          cnt_q <= last_clk ? `BM_LEN_ONE : cnt_q + `BM_LEN_ONE;
          if (last_clk) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data capture and completion
  // ----------------------------------------------------------------
  logic cap_classic, cap_latch;

  assign cap_classic = state_q == ST_T3 && last_clk && mode_q == `BM_MODE_CLASSIC;
  assign cap_latch   = state_q == ST_T3 && last_clk && mode_q == `BM_MODE_LATCH;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cpu_rdata_o <= '0;
    end else if ((cap_classic || cap_latch) && !write_q) begin
      cpu_rdata_o <= data_i;
    end else if (!granted_q && cpu_req_i && !shaped && !cpu_write_i) begin
      cpu_rdata_o <= data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (cap_classic || (state_q == ST_T4 && last_clk));
    end
  end

  assign cpu_ready_o = granted_q ? 1'b0 : (shaped || state_q != ST_IDLE) ? done_q : 1'b1;

  // ----------------------------------------------------------------
  // Bus arbitration
  // ----------------------------------------------------------------
  // Grant only between cycles
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      granted_q <= 1'b0;
    end else if (state_q == ST_IDLE && !start) begin
      granted_q <= breq;
    end
  end

  assign bus_grant_out_n_o = !granted_q;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic busy, t2_on, strobe_on, ale_high;

  assign busy      = state_q != ST_IDLE;
  assign t2_on     = state_q == ST_T2 || state_q == ST_WAIT || state_q == ST_T3;
  assign strobe_on = t2_on;
  // Strobe high for first half of T1
  assign ale_high  = state_q == ST_T1 && mode_q == `BM_MODE_LATCH &&
                     ({cnt_q, 1'b0} <= {1'b0, len_q});

  always_comb begin
    addr_oe_o              = !granted_q;
    addr_o                 = cpu_addr_i;
    data_oe_o              = !granted_q && cpu_write_i && cpu_req_i;
    data_o                 = cpu_wdata_i;
    cs_n_o                 = ~sel;
    read_strobe_n_o        = granted_q || cpu_rd_n_i;
    write_strobe_n_o       = granted_q || cpu_wr_n_i;
    memory_request_n_o     = granted_q || !(cpu_mem_i && cpu_req_i);
    io_request_n_o         = granted_q || !(cpu_io_i && cpu_req_i);
    address_latch_strobe_o = 1'b0;
    if (granted_q) begin
      cs_n_o = ~sel;
    end else if (busy) begin
      addr_o                 = addr_q;
      // Address and select held whole cycle
      cs_n_o                 = ~sel_q;
      read_strobe_n_o        = !(strobe_on && !write_q);
      write_strobe_n_o       = !(strobe_on && write_q);
      memory_request_n_o     = !(t2_on && mem_q);
      io_request_n_o         = !(t2_on && !mem_q);
      address_latch_strobe_o = ale_high;
      // Address low byte on data in T1
      if (mux_q && state_q == ST_T1) begin
        data_oe_o = 1'b1;
        data_o    = addr_q[`BM_DATA_W-1:0];
      end else begin
        data_oe_o = write_q;
        data_o    = wdata_q;
      end
    end else if (shaped) begin
      // Hold the pins quiet until the shaped cycle starts.
      cs_n_o             = '1;
      read_strobe_n_o    = 1'b1;
      write_strobe_n_o   = 1'b1;
      memory_request_n_o = 1'b1;
      io_request_n_o     = 1'b1;
      data_oe_o          = 1'b0;
    end
  end

  assign inserted_wait_state_o = state_q == ST_WAIT;
endmodule : bus_mode_ctrl

// File: verif/bus_mode_ctrl_assertions.sv
// Port checker for the bus mode controller.
`timescale 1ns/1ps
`include "bus_mode_consts.svh"
module bus_mode_ctrl_assertions #(
  parameter int NUM_CS = `BM_NUM_CS
) (
  // Clock and reset
  input wire logic                         mclk_i,
  input wire logic                         rst_i,
  // Inputs watched
  input wire logic [NUM_CS*`BM_MODE_W-1:0] cs_mode_i,
  input wire logic                         cpu_rd_n_i,
  input wire logic                         cpu_wr_n_i,
  input wire logic                         wait_n_i,
  // Outputs watched
  input wire logic                         bus_grant_out_n_o,
  input wire logic                         ext_internal_hit_o,
  input wire logic [`BM_ADDR_W-1:0]        addr_o,
  input wire logic                         addr_oe_o,
  input wire logic                         data_oe_o,
  input wire logic [NUM_CS-1:0]            cs_n_o,
  input wire logic                         read_strobe_n_o,
  input wire logic                         write_strobe_n_o,
  input wire logic                         memory_request_n_o,
  input wire logic                         io_request_n_o,
  input wire logic                         address_latch_strobe_o,
  input wire logic                         inserted_wait_state_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_in_wait;
    inserted_wait_state_o;
  endsequence
  sequence s_cs_release;
    $rose(&cs_n_o) && bus_grant_out_n_o;
  endsequence
  a_grant_release: assert property (!bus_grant_out_n_o |-> !addr_oe_o && !data_oe_o)
    else $error("bus still driven while granted");
  a_internal_ignored: assert property (ext_internal_hit_o |-> &cs_n_o)
    else $error("chip select on internal register access");
  a_cs_one_only: assert property ($onehot0(~cs_n_o))
    else $error("more than one chip select low");
  a_native_pass: assert property ((cs_mode_i == '0) && bus_grant_out_n_o |->
    read_strobe_n_o == cpu_rd_n_i && write_strobe_n_o == cpu_wr_n_i)
    else $error("native strobes not passed through");
  a_request_kind: assert property (!read_strobe_n_o || !write_strobe_n_o |->
    memory_request_n_o != io_request_n_o)
    else $error("strobe without exactly one request");
  a_latch_first: assert property (address_latch_strobe_o |->
    read_strobe_n_o && write_strobe_n_o)
    else $error("latch strobe overlaps a data strobe");
  a_latch_fall_cs: assert property ($fell(address_latch_strobe_o) |-> !(&cs_n_o))
    else $error("latch strobe fell without chip select");
  a_wait_hold: assert property (s_in_wait |=> $stable({cs_n_o, read_strobe_n_o,
    write_strobe_n_o, addr_o}))
    else $error("bus changed after a wait state");
  a_wait_cause: assert property ($rose(inserted_wait_state_o) |-> !($past(wait_n_i, 1)
    && $past(wait_n_i, 2) && $past(wait_n_i, 3) && $past(wait_n_i, 4)))
    else $error("wait state without wait pin low");
  a_idle_return: assert property (s_cs_release |-> read_strobe_n_o && write_strobe_n_o
    && memory_request_n_o && io_request_n_o && !address_latch_strobe_o)
    else $error("strobes active after chip select release");
endmodule : bus_mode_ctrl_assertions
bind bus_mode_ctrl bus_mode_ctrl_assertions #(.NUM_CS(NUM_CS)) u_chk (.mclk_i, .rst_i,
  .cs_mode_i, .cpu_rd_n_i, .cpu_wr_n_i, .wait_n_i, .bus_grant_out_n_o, .ext_internal_hit_o,
  .addr_o, .addr_oe_o, .data_oe_o, .cs_n_o, .read_strobe_n_o, .write_strobe_n_o,
  .memory_request_n_o, .io_request_n_o, .address_latch_strobe_o, .inserted_wait_state_o);

// File: verif/ext_mem_model.sv
// Behavioural external memory with a wait pin.
`timescale 1ns/1ps
module ext_mem_model (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Bus pins from the controller, plus the wait hold count from the testbench
  input  wire logic [3:0] cs_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [3:0] hold_i,
  // Pins back to the controller, plus the last written byte for the testbench
  output logic      [7:0] rdata_o,
  output logic            wait_n_o,
  output logic      [7:0] last_wr_o
);
  logic [7:0] last_q;
  logic [3:0] cnt_q;
  logic       strb_q;
  assign rdata_o = (!rd_n_i && !(&cs_n_i)) ? (addr_i ^ 8'h5a) : ~last_q;
  assign wait_n_o = (cnt_q == 4'h0);
  always_ff @(posedge mclk_i) begin
    strb_q <= rd_n_i & wr_n_i;
    last_q <= rdata_o;
    if (rst_i) cnt_q <= 4'h0;
    else if (strb_q && !(rd_n_i & wr_n_i)) cnt_q <= hold_i;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    if (!wr_n_i && !(&cs_n_i)) last_wr_o <= wdata_i;
  end
endmodule : ext_mem_model

// File: verif/bus_mode_ctrl_test.sv
// Testbench for the bus mode controller.
`timescale 1ns/1ps
module bus_mode_ctrl_test;
  logic        mclk_i, rst_i, cpu_req_i, cpu_write_i, cpu_mem_i, cpu_io_i, cpu_rd_n_i;
  logic        cpu_wr_n_i, cpu_ready_o, bus_request_in_n_i, bus_grant_out_n_o, ext_mem_n_i;
  logic        ext_io_n_i, ext_internal_hit_o, wait_n_i, addr_oe_o, data_oe_o;
  logic        read_strobe_n_o, write_strobe_n_o, memory_request_n_o, io_request_n_o;
  logic        address_latch_strobe_o, inserted_wait_state_o;
  logic [3:0]  cs_en_i, cs_io_i, cs_mux_i, cs_n_o, hold;
  logic [31:0] cs_lbr_i, cs_ubr_i;
  logic [7:0]  cs_mode_i, cpu_wdata_i, cpu_rdata_o, data_o, data_i, last_wr;
  logic [15:0] cs_len_i;
  logic [23:0] cpu_addr_i, addr_o, addr_i;
  int          n_mismatch, num_checks, cycles, k;
  // Chip select, mode, length, write, mux, wait hold, effective length.
  int tv [8][7] = '{'{0, 1, 0, 0, 0, 0, 1}, '{0, 1, 1, 1, 0, 0, 1}, '{1, 1, 15, 0, 0, 0, 15},
    '{2, 2, 1, 0, 0, 0, 2}, '{2, 2, 2, 0, 1, 0, 2}, '{3, 2, 15, 1, 0, 0, 15},
    '{0, 1, 6, 0, 0, 3, 6}, '{3, 2, 6, 0, 0, 3, 6}};
  bus_mode_ctrl DUT (.mclk_i, .rst_i, .cs_en_i, .cs_io_i, .cs_lbr_i, .cs_ubr_i, .cs_mode_i,
    .cs_len_i, .cs_mux_i, .cpu_req_i, .cpu_write_i, .cpu_mem_i, .cpu_io_i, .cpu_addr_i,
    .cpu_wdata_i, .cpu_rd_n_i, .cpu_wr_n_i, .cpu_ready_o, .cpu_rdata_o, .bus_request_in_n_i,
    .bus_grant_out_n_o, .ext_mem_n_i, .ext_io_n_i, .ext_internal_hit_o, .wait_n_i, .addr_o,
    .addr_i, .addr_oe_o, .data_o, .data_i, .data_oe_o, .cs_n_o, .read_strobe_n_o,
    .write_strobe_n_o, .memory_request_n_o, .io_request_n_o, .address_latch_strobe_o,
    .inserted_wait_state_o);
  ext_mem_model u_mem (.mclk_i, .rst_i, .cs_n_i(cs_n_o), .rd_n_i(read_strobe_n_o),
    .wr_n_i(write_strobe_n_o), .addr_i(addr_o[7:0]), .wdata_i(data_o), .hold_i(hold),
    .rdata_o(data_i), .wait_n_o(wait_n_i), .last_wr_o(last_wr));
  // ----
  // Tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic shaped(input int g, m, l, wr, mx, h, el);
    int          ncs, nst, nale, nw, nmr, j;
    logic [23:0] a;
    @(negedge mclk_i);
    a = {8'(g * 64 + 5), 8'h12, 8'(g + 48)};
    {ncs, nst, nale, nw, nmr} = '0;
    cs_mode_i[g*2+:2] = 2'(m);
    cs_len_i[g*4+:4] = 4'(l);
    cs_mux_i[g] = 1'(mx);
    hold = 4'(h);
    cpu_addr_i = a;
    cpu_write_i = 1'(wr);
    cpu_wdata_i = a[7:0] ^ 8'hc3;
    cpu_req_i = 1'b1;
    @(negedge mclk_i);
    for (j = 0; j < 300 && cpu_ready_o !== 1'b1; j++) begin
      ncs += int'(cs_n_o[g] === 1'b0);
      nst += int'(read_strobe_n_o === 1'b0 || write_strobe_n_o === 1'b0);
      nale += int'(address_latch_strobe_o === 1'b1);
      nw += int'(inserted_wait_state_o === 1'b1);
      nmr += int'(memory_request_n_o === 1'b0 && io_request_n_o === 1'b1);
      if (address_latch_strobe_o === 1'b1 && mx == 1)
        check("mux", {data_oe_o, data_o}, {1'b1, a[7:0]});
      @(negedge mclk_i);
    end
    @(posedge mclk_i);
    @(negedge mclk_i);
    cpu_req_i = 1'b0;
    check("answer", j - nw, (m + 2) * el);
    check("cs", ncs - nw, (m + 2) * el);
    check("strobe", nst - nw, 2 * el);
    check("request", nmr - nw, 2 * el);
    check("ale", nale, (m == 2) ? el / 2 : 0);
    check("wait", int'(nw > 0), int'(h > 0));
    check("idle", {cs_n_o[g], read_strobe_n_o, write_strobe_n_o}, 3'b111);
    if (wr == 1) check("wdata", last_wr, a[7:0] ^ 8'hc3);
    else check("rdata", cpu_rdata_o, a[7:0] ^ 8'h5a);
    $display("test done: cs %0d mode %0d len %0d", g, m, l);
  endtask : shaped
  // ----
  // Clock, timeout and sequence
  // ----
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles >= 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    {rst_i, cpu_mem_i, cpu_rd_n_i, cpu_wr_n_i, bus_request_in_n_i, ext_mem_n_i} = 6'h3f;
    {ext_io_n_i, cpu_req_i, cpu_write_i, cpu_io_i} = 4'h8;
    {cs_en_i, cs_io_i, cs_mux_i, cs_mode_i, cs_len_i, hold} = {4'hf, 36'h0};
    {cs_lbr_i, cs_ubr_i} = {32'hc080_4000, 32'hffbf_7f3f};
    {cpu_addr_i, addr_i, cpu_wdata_i} = '0;
    {n_mismatch, num_checks, cycles} = '0;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    cpu_addr_i = 24'h85_0000;
    cpu_rd_n_i = 1'b0;
    cpu_req_i = 1'b1;
    @(negedge mclk_i);
    check("native rd", {cs_n_o, read_strobe_n_o, memory_request_n_o}, 6'h2c);
    cpu_rd_n_i = 1'b1;
    cpu_wr_n_i = 1'b0;
    @(negedge mclk_i);
    check("native wr", {write_strobe_n_o, read_strobe_n_o}, 2'b01);
    cpu_wr_n_i = 1'b1;
    cpu_req_i = 1'b0;
    $display("test done: native");
    for (k = 0; k < 8; k++)
      shaped(tv[k][0], tv[k][1], tv[k][2], tv[k][3], tv[k][4], tv[k][5], tv[k][6]);
    bus_request_in_n_i = 1'b0;
    for (k = 0; k < 20 && bus_grant_out_n_o !== 1'b0; k++) @(negedge mclk_i);
    check("grant", {bus_grant_out_n_o, addr_oe_o, data_oe_o}, 3'b000);
    addr_i = 24'h45_0000;
    ext_mem_n_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    check("ext cs", cs_n_o, 4'b1101);
    // An io chip select on the internal page would fire if internal hits were not ignored.
    cs_io_i[3] = 1'b1;
    cs_lbr_i[31:24] = 8'h00;
    {ext_mem_n_i, ext_io_n_i, addr_i, cpu_req_i} = {2'b10, 24'h00_0012, 1'b1};
    repeat (4) @(negedge mclk_i);
    check("ext hit", {ext_internal_hit_o, cs_n_o, cpu_ready_o}, 6'h3e);
    {cpu_req_i, ext_io_n_i, bus_request_in_n_i} = 3'b011;
    for (k = 0; k < 20 && bus_grant_out_n_o !== 1'b1; k++) @(negedge mclk_i);
    check("release", bus_grant_out_n_o, 1'b1);
    $display("test done: grant");
    give_verdict();
  end
endmodule : bus_mode_ctrl_test
